/* File: ctg_consts.vh */
`ifndef CTG_CONSTS_VH
`define CTG_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTG_ADDR_CTRL 4'h0
`define CTG_ADDR_TRW 4'h1
`define CTG_ADDR_GUARD 4'h2
`define CTG_ADDR_RSW 4'h3
`define CTG_ADDR_RSD 4'h4
`define CTG_ADDR_REFD 4'h5
`define CTG_ADDR_SIGD 4'h6
`define CTG_ADDR_STAT 4'h7
`define CTG_ADDR_DATA 4'h8
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTG_CTRL_EO_BIT 0
`define CTG_CTRL_EN_BIT 1
`define CTG_CTRL_RST 2'h2
`define CTG_TRW_RST 8'h28
`define CTG_GUARD_RST 8'h04
`define CTG_RSW_RST 8'h01
`define CTG_RSD_RST 8'h01
`define CTG_REFD_RST 8'h03
`define CTG_SIGD_RST 8'h07
// ----------------------------------------
// Timing
// ----------------------------------------
`define CTG_MCLK_NS 25
`define CTG_PH_HALF_STD 8'h04
`define CTG_PH_HALF_EO 8'h08
`define CTG_EOC_CYC 3'h5
`define CTG_HOLD_NS 300
`define CTG_HOLD_CYC ((`CTG_HOLD_NS + `CTG_MCLK_NS - 1) / `CTG_MCLK_NS)
`endif

/* File: ctg_sync2.v */
`timescale 1ns/100ps
module ctg_sync2 (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Level
   input wire i_d,
   output reg o_q
);
   reg meta_r;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= 1'b0;
         o_q <= 1'b0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule

/* File: ctg_pulse.v */
`timescale 1ns/100ps
`include "ctg_consts.vh"
// Fires a pulse of i_width cycles starting i_delay cycles after i_start.
module ctg_pulse (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Control
   input wire i_start,
   input wire [7:0] i_delay,
   input wire [7:0] i_width,
   // Pulse
   output reg o_pulse
);
   reg [7:0] dly_r;
   reg [7:0] wid_r;
   reg arm_r;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dly_r <= 8'h00;
         wid_r <= 8'h00;
         arm_r <= 1'b0;
         o_pulse <= 1'b0;
      end else begin
         if (i_start) begin
            arm_r <= 1'b1;
            dly_r <= i_delay;
         end else if (arm_r) begin
            if (dly_r <= 8'h01) begin
               arm_r <= 1'b0;
               o_pulse <= 1'b1;
               wid_r <= (i_width == 8'h00) ? 8'h01 : i_width;
            end else begin
               dly_r <= dly_r - 8'h01;
            end
         end
         if (o_pulse && !(arm_r && dly_r <= 8'h01 && !i_start)) begin
            if (wid_r <= 8'h01) begin
               o_pulse <= 1'b0;
            end
            wid_r <= wid_r - 8'h01;
         end
      end
   end
endmodule

/* File: ctg_timing_gen.v */
//
// How it works
// - First phase-one high comes one master clock after the generator starts.
// - Phase clocks run at master divided by 8, or 16 in even/odd mode.
// - Phase clocks are high and low for equal master-clock counts, except through a line transfer, which holds phase one low and phase two high.
// - Transfer pulse width comes from a configuration register.
// - Programmable guard time around the transfer pulse relative to phase one.
// - Sensor reset pulse width comes from a configuration register.
// - Reset pulse delayed from phase-one fall, or either edge in even/odd mode.
// - Reference sample delayed from phase-one fall, or either edge in even/odd.
// - Signal sample delayed from phase-one fall, or either edge in even/odd.
// - Each sample strobe is high for exactly one master clock.
// - Pixel data stays valid at least 300 ns after conversion strobe falls.
//
`timescale 1ns/100ps
`include "ctg_consts.vh"
module ctg_timing_gen (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Register port
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Host line sync (pin)
   input wire i_line_sync,
   // Conversion results
   input wire [7:0] i_pix_data,
   input wire i_pix_done,
   output reg [7:0] o_pix_data,
   output reg o_eoc,
   output reg o_conversion_clock_out,
   // Sensor drive
   output reg o_phase1,
   output reg o_phase2,
   output wire o_sensor_reset_pulse,
   output reg o_sensor_transfer_pulse,
   output wire o_sample_ref,
   output wire o_sample_sig
);
   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   reg [1:0] ctrl_r;
   reg [7:0] trw_r;
   reg [7:0] guard_r;
   reg [7:0] rsw_r;
   reg [7:0] rsd_r;
   reg [7:0] refd_r;
   reg [7:0] sigd_r;
   wire eo_mode = ctrl_r[`CTG_CTRL_EO_BIT];
   wire enable = ctrl_r[`CTG_CTRL_EN_BIT];
   wire [7:0] half_len = eo_mode ? `CTG_PH_HALF_EO : `CTG_PH_HALF_STD;
   reg [7:0] pix_r;
   reg line_end_r;
   reg [1:0] xf_st_r;

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= `CTG_CTRL_RST;
         trw_r <= `CTG_TRW_RST;
         guard_r <= `CTG_GUARD_RST;
         rsw_r <= `CTG_RSW_RST;
         rsd_r <= `CTG_RSD_RST;
         refd_r <= `CTG_REFD_RST;
         sigd_r <= `CTG_SIGD_RST;
      end else if (i_wr) begin
         case (i_addr)
            `CTG_ADDR_CTRL: ctrl_r <= i_wdata[1:0];
            `CTG_ADDR_TRW: trw_r <= i_wdata;
            `CTG_ADDR_GUARD: guard_r <= i_wdata;
            `CTG_ADDR_RSW: rsw_r <= i_wdata;
            `CTG_ADDR_RSD: rsd_r <= i_wdata;
            `CTG_ADDR_REFD: refd_r <= i_wdata;
            `CTG_ADDR_SIGD: sigd_r <= i_wdata;
            default: ;
         endcase
      end
   end

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `CTG_ADDR_CTRL: o_rdata <= {6'h00, ctrl_r};
            `CTG_ADDR_TRW: o_rdata <= trw_r;
            `CTG_ADDR_GUARD: o_rdata <= guard_r;
            `CTG_ADDR_RSW: o_rdata <= rsw_r;
            `CTG_ADDR_RSD: o_rdata <= rsd_r;
            `CTG_ADDR_REFD: o_rdata <= refd_r;
            `CTG_ADDR_SIGD: o_rdata <= sigd_r;
            `CTG_ADDR_STAT: o_rdata <= {4'h0, xf_st_r, o_phase1, line_end_r};
            `CTG_ADDR_DATA: o_rdata <= pix_r;
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Phase clock divider
   // ----------------------------------------
   reg [7:0] ph_cnt_r;
   reg started_r;
   reg hold_r;
   // A count past the end, left by a live mode change, toggles at once instead of wrapping.
   wire ph_toggle = started_r && !hold_r && (ph_cnt_r >= half_len - 8'h01);
   wire ph1_fall = ph_toggle && o_phase1;
   wire ph1_rise = ph_toggle && !o_phase1;
   // Standard mode keys off the fall only; even/odd uses both edges.
   wire ph1_ref = eo_mode ? ph_toggle : ph1_fall;

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ph_cnt_r <= 8'h00;
         started_r <= 1'b0;
         o_phase1 <= 1'b0;
         o_phase2 <= 1'b0;
      end else if (!enable) begin
         ph_cnt_r <= 8'h00;
         started_r <= 1'b0;
         o_phase1 <= 1'b0;
         o_phase2 <= 1'b0;
      end else if (!started_r) begin
         started_r <= 1'b1;
         o_phase1 <= 1'b1;
         o_phase2 <= 1'b0;
         ph_cnt_r <= 8'h00;
      end else if (!hold_r) begin
         if (ph_toggle) begin
            ph_cnt_r <= 8'h00;
            o_phase1 <= ~o_phase1;
            o_phase2 <= o_phase1;
         end else begin
            ph_cnt_r <= ph_cnt_r + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Line sync and transfer pulse
   // ----------------------------------------
   localparam XF_IDLE = 2'h0;
   localparam XF_GUARD1 = 2'h1;
   localparam XF_PULSE = 2'h2;
   localparam XF_GUARD2 = 2'h3;
   wire sync_s;
   reg sync_d_r;
   reg [7:0] xf_cnt_r;

   ctg_sync2 u_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_d(i_line_sync),
      .o_q(sync_s)
   );

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_d_r <= 1'b0;
         line_end_r <= 1'b0;
         xf_st_r <= XF_IDLE;
         xf_cnt_r <= 8'h00;
         hold_r <= 1'b0;
         o_sensor_transfer_pulse <= 1'b0;
      end else begin
         sync_d_r <= sync_s;
         if (sync_s && !sync_d_r) begin
            line_end_r <= 1'b1;
         end
         case (xf_st_r)
            XF_IDLE: begin
               if (line_end_r && ph1_fall) begin
                  line_end_r <= sync_s && !sync_d_r;
                  hold_r <= 1'b1;
                  xf_cnt_r <= guard_r;
                  xf_st_r <= XF_GUARD1;
               end
            end
            XF_GUARD1: begin
               if (xf_cnt_r <= 8'h01) begin
                  o_sensor_transfer_pulse <= 1'b1;
                  xf_cnt_r <= trw_r;
                  xf_st_r <= XF_PULSE;
               end else begin
                  xf_cnt_r <= xf_cnt_r - 8'h01;
               end
            end
            XF_PULSE: begin
               if (xf_cnt_r <= 8'h01) begin
                  o_sensor_transfer_pulse <= 1'b0;
                  xf_cnt_r <= guard_r;
                  xf_st_r <= XF_GUARD2;
               end else begin
                  xf_cnt_r <= xf_cnt_r - 8'h01;
               end
            end
            XF_GUARD2: begin
               if (xf_cnt_r <= 8'h01) begin
                  hold_r <= 1'b0;
                  xf_st_r <= XF_IDLE;
               end else begin
                  xf_cnt_r <= xf_cnt_r - 8'h01;
               end
            end
            default: xf_st_r <= XF_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Reset pulse and sample strobes
   // ----------------------------------------
   wire [7:0] dly_tab [0:2];
   wire [7:0] wid_tab [0:2];
   wire [2:0] pulses;
   assign dly_tab[0] = rsd_r;
   assign dly_tab[1] = refd_r;
   assign dly_tab[2] = sigd_r;
   assign wid_tab[0] = rsw_r;
   assign wid_tab[1] = 8'h01;
   assign wid_tab[2] = 8'h01;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pulse
         ctg_pulse u_pulse (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .i_start(ph1_ref && !hold_r),
            .i_delay(dly_tab[g]),
            .i_width(wid_tab[g]),
            .o_pulse(pulses[g])
         );
      end
   endgenerate
   assign o_sensor_reset_pulse = pulses[0];
   assign o_sample_ref = pulses[1];
   assign o_sample_sig = pulses[2];

   // ----------------------------------------
   // End of conversion and data hold
   // ----------------------------------------
   localparam [31:0] HOLD_FULL = `CTG_HOLD_CYC;
   reg [2:0] eoc_cnt_r;
   reg [7:0] hold_cnt_r;

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pix_r <= 8'h00;
         o_pix_data <= 8'h00;
         o_eoc <= 1'b0;
         o_conversion_clock_out <= 1'b0;
         eoc_cnt_r <= 3'h0;
         hold_cnt_r <= 8'h00;
      end else begin
         if (i_pix_done && hold_cnt_r == 8'h00 && !o_eoc) begin
            pix_r <= i_pix_data;
            o_pix_data <= i_pix_data;
            o_eoc <= 1'b1;
            o_conversion_clock_out <= 1'b1;
            eoc_cnt_r <= `CTG_EOC_CYC;
         end else if (o_eoc) begin
            if (eoc_cnt_r <= 3'h1) begin
               o_eoc <= 1'b0;
               o_conversion_clock_out <= 1'b0;
               hold_cnt_r <= HOLD_FULL[7:0];
            end
            eoc_cnt_r <= eoc_cnt_r - 3'h1;
         end else if (hold_cnt_r != 8'h00) begin
            hold_cnt_r <= hold_cnt_r - 8'h01;
         end
      end
   end

   // is kept by the host; a new sync rise only sets line_end_r.
endmodule

/* File: ctg_timing_gen_props.sv */
`timescale 1ns/100ps
`include "ctg_consts.vh"
module ctg_timing_gen_chk (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Register port
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   // Outputs watched
   input wire [7:0] o_pix_data,
   input wire o_eoc,
   input wire o_conversion_clock_out,
   input wire o_phase1,
   input wire o_sensor_reset_pulse,
   input wire o_sensor_transfer_pulse,
   input wire o_sample_ref,
   input wire o_sample_sig
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Mirror of the even/odd mode bit, tracked from register writes.
   reg eo_r;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) eo_r <= 1'b0;
      else if (i_wr && i_addr == `CTG_ADDR_CTRL) eo_r <= i_wdata[`CTG_CTRL_EO_BIT];
   end
   // A write takes two cycles to reach the phase divider, so half-period checks pause that long.
   reg [1:0] wr_hist_r;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) wr_hist_r <= 2'b00;
      else wr_hist_r <= {wr_hist_r[0], i_wr};
   end
   chk_phase_start:
      assert property ($rose(i_rst_n) |=> o_phase1) else $error("phase one late after reset");
   chk_half_std:
      assert property (disable iff (!i_rst_n || i_wr || wr_hist_r != 2'b00)
         $rose(o_phase1) && !eo_r |-> o_phase1[*4] ##1 !o_phase1)
      else $error("standard half period wrong");
   chk_half_eo:
      assert property (disable iff (!i_rst_n || i_wr || wr_hist_r != 2'b00)
         $rose(o_phase1) && eo_r |-> o_phase1[*8] ##1 !o_phase1)
      else $error("even/odd half period wrong");
   chk_ref_width:
      assert property ($rose(o_sample_ref) |=> !o_sample_ref) else $error("reference strobe width wrong");
   chk_sig_width:
      assert property ($rose(o_sample_sig) |=> !o_sample_sig) else $error("signal strobe width wrong");
   chk_reset_to_ref:
      assert property ($rose(o_sensor_reset_pulse) |=> !o_sensor_reset_pulse ##1 $rose(o_sample_ref))
      else $error("reset pulse and reference strobe misplaced");
   chk_ref_to_sig:
      assert property ($rose(o_sample_ref) |-> ##4 $rose(o_sample_sig)) else $error("signal strobe misplaced");
   chk_xfer_width:
      assert property ($rose(o_sensor_transfer_pulse) |-> ##39 o_sensor_transfer_pulse ##1 !o_sensor_transfer_pulse)
      else $error("transfer pulse width wrong");
   chk_xfer_guard:
      assert property ($fell(o_sensor_transfer_pulse) |-> !o_phase1[*4]) else $error("guard after transfer short");
   chk_eoc_width:
      assert property ($rose(o_eoc) |-> (o_eoc && o_conversion_clock_out)[*5] ##1 !o_eoc)
      else $error("conversion strobe width wrong");
   chk_data_hold:
      assert property ($fell(o_eoc) |-> $stable(o_pix_data)[*8] ##1 $stable(o_pix_data)[*4])
      else $error("pixel data changed in hold");
endmodule
bind ctg_timing_gen ctg_timing_gen_chk u_chk (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .o_pix_data, .o_eoc,
   .o_conversion_clock_out, .o_phase1, .o_sensor_reset_pulse, .o_sensor_transfer_pulse, .o_sample_ref, .o_sample_sig);

/* File: ctg_host_model.sv */
`timescale 1ns/100ps
module ctg_host_model (
   // Clock
   input wire i_mclk,
   // Requests from the bench
   input wire i_line_req,
   input wire i_pix_req,
   input wire [7:0] i_pix_val,
   // Pins toward the block
   output reg o_line_sync = 1'b0,
   output reg [7:0] o_pix_data = 8'h00,
   output reg o_pix_done = 1'b0
);
   reg [2:0] cnt_r = 3'h0;
   // Sync stays high four cycles, then low at least two before a new line.
   always @(posedge i_mclk) begin
      if (i_line_req && cnt_r == 3'h0) cnt_r <= 3'h6;
      else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      o_line_sync <= (i_line_req && cnt_r == 3'h0) || cnt_r > 3'h3;
      o_pix_done <= i_pix_req;
      // Between results the data lines carry a moving pattern.
      o_pix_data <= i_pix_req ? i_pix_val : ~o_pix_data;
   end
endmodule

/* File: ctg_timing_gen_test.sv */
`timescale 1ns/100ps
`include "ctg_consts.vh"
module ctg_timing_gen_test;
   reg i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, line_req = 1'b0, pix_req = 1'b0;
   reg [3:0] i_addr = 4'h0;
   reg [7:0] i_wdata = 8'h00, pix_val = 8'h00, rd_v;
   wire [7:0] o_rdata, o_pix_data, pix_data;
   wire o_eoc, o_conv_clk, o_phase1, o_phase2, o_rst_pulse, o_xfer, o_ref, o_sig, line_sync, pix_done;
   integer fails = 0, comparisons = 0, k;
   ctg_timing_gen dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_line_sync(line_sync), .i_pix_data(pix_data), .i_pix_done(pix_done),
      .o_pix_data(o_pix_data), .o_eoc(o_eoc), .o_conversion_clock_out(o_conv_clk), .o_phase1(o_phase1),
      .o_phase2(o_phase2), .o_sensor_reset_pulse(o_rst_pulse), .o_sensor_transfer_pulse(o_xfer),
      .o_sample_ref(o_ref), .o_sample_sig(o_sig));
   ctg_host_model u_host (.i_mclk(i_mclk), .i_line_req(line_req), .i_pix_req(pix_req), .i_pix_val(pix_val),
      .o_line_sync(line_sync), .o_pix_data(pix_data), .o_pix_done(pix_done));
   initial begin
      forever #12.5 i_mclk = ~i_mclk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task step;
      @(posedge i_mclk);
      #1;
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task rdchk(input [3:0] a, input [7:0] e, input [63:0] nm);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(nm, e, o_rdata);
   endtask
   task finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rdchk(`CTG_ADDR_CTRL, {6'h00, `CTG_CTRL_RST}, "ctrl");
      rdchk(`CTG_ADDR_TRW, `CTG_TRW_RST, "trw");
      rdchk(`CTG_ADDR_GUARD, `CTG_GUARD_RST, "guard");
      rdchk(`CTG_ADDR_RSW, `CTG_RSW_RST, "rsw");
      rdchk(`CTG_ADDR_RSD, `CTG_RSD_RST, "rsd");
      rdchk(`CTG_ADDR_REFD, `CTG_REFD_RST, "refd");
      rdchk(`CTG_ADDR_SIGD, `CTG_SIGD_RST, "sigd");
      wr(4'hF, 8'h5A);
      rdchk(4'hF, 8'h00, "unmapped");
      $display("test regs done");
   endtask
   task t_phase(input eo, input [7:0] half);
      wr(`CTG_ADDR_CTRL, 8'h00);
      repeat (2) step;
      chk("ph_off", 8'h00, {7'h00, o_phase1});
      wr(`CTG_ADDR_CTRL, {6'h00, 1'b1, eo});
      #1 chk("ph_wait", 8'h00, {7'h00, o_phase1});
      step;
      chk("ph_start", 8'h01, {7'h00, o_phase1});
      repeat (2) begin
         k = 0;
         while (o_phase1 !== 1'b0 && k < 40) begin step; k = k + 1; end
         while (o_phase1 !== 1'b1 && k < 80) begin step; k = k + 1; end
      end
      for (k = 0; o_phase1 === 1'b1 && k < 40; k = k + 1) step;
      chk("ph_high", half, k[7:0]);
      for (k = 0; o_phase1 === 1'b0 && k < 40; k = k + 1) step;
      chk("ph_low", half, k[7:0]);
      chk("ph2", {7'h00, ~o_phase1}, {7'h00, o_phase2});
      $display("test phase done");
   endtask
   task t_strobe;
      for (k = 0; o_rst_pulse !== 1'b1 && k < 40; k = k + 1) step;
      for (k = 0; o_ref !== 1'b1 && k < 40; k = k + 1) step;
      chk("rst_ref", `CTG_REFD_RST - `CTG_RSD_RST, k[7:0]);
      step;
      chk("ref_w", 8'h00, {7'h00, o_ref});
      for (k = 1; o_sig !== 1'b1 && k < 40; k = k + 1) step;
      chk("ref_sig", `CTG_SIGD_RST - `CTG_REFD_RST, k[7:0]);
      $display("test strobe done");
   endtask
   task t_line;
      @(posedge i_mclk) line_req <= 1'b1;
      @(posedge i_mclk) line_req <= 1'b0;
      for (k = 0; o_xfer !== 1'b1 && k < 200; k = k + 1) step;
      chk("ph_in_xf", 8'h00, {7'h00, o_phase1});
      for (k = 0; o_xfer === 1'b1 && k < 200; k = k + 1) step;
      chk("xfer_w", `CTG_TRW_RST, k[7:0]);
      for (k = 0; o_phase1 !== 1'b1 && k < 40; k = k + 1) step;
      chk("guard", 8'h01, {7'h00, k >= `CTG_GUARD_RST});
      $display("test line done");
   endtask
   task pix(input [7:0] v);
      @(posedge i_mclk) pix_val <= v;
      pix_req <= 1'b1;
      @(posedge i_mclk) pix_req <= 1'b0;
      #1;
   endtask
   task t_eoc;
      pix(8'hA5);
      for (k = 0; o_eoc !== 1'b1 && k < 10; k = k + 1) step;
      chk("conv_clk", 8'h01, {7'h00, o_conv_clk});
      for (k = 0; o_eoc === 1'b1 && k < 20; k = k + 1) step;
      chk("eoc_w", {5'h00, `CTG_EOC_CYC}, k[7:0]);
      pix(8'h3C);
      repeat (8) step;
      chk("hold", 8'hA5, o_pix_data);
      rdchk(`CTG_ADDR_DATA, 8'hA5, "data");
      repeat (`CTG_HOLD_CYC) step;
      pix(8'h3C);
      for (k = 0; o_eoc !== 1'b1 && k < 10; k = k + 1) step;
      chk("new", 8'h3C, o_pix_data);
      $display("test eoc done");
   endtask
   initial begin
      #200000;
      fails = fails + 1;
      finish_test;
   end
   initial begin
      repeat (6) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_regs;
      t_phase(1'b0, `CTG_PH_HALF_STD);
      t_strobe;
      t_line;
      t_eoc;
      t_phase(1'b1, `CTG_PH_HALF_EO);
      t_strobe;
      finish_test;
   end
endmodule
